// ### core/in_chan.sv
// one physical input: synchroniser, polarity and simulation overlay
`default_nettype none
module in_chan (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic pin,
   input  wire logic invert,
   input  wire logic sim,
   output var  logic level
);
   logic sync1_reg;
   logic sync2_reg;
   logic level_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
      end
   end

   // pin level xor polarity bit, or simulation bit, ahead of status and function decode (see R18)
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) level_reg <= 1'b0;
      else       level_reg <= (sync2_reg ^ invert) | sim; // see R4
   end

   assign level = level_reg;
endmodule
`default_nettype wire

// ### core/io_map_pkg.sv
// shared constants, codes and carrier types of the servo i/o function mapper
`default_nettype none
package io_map_pkg;

   // ----------------------------------------------------------------
   // parameter offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] OFF_IN_POL     = 16'h0810;
   localparam logic [15:0] OFF_IN_SIM     = 16'h0820;
   localparam logic [15:0] OFF_IN1_SEL    = 16'h0830;
   localparam logic [15:0] OFF_IN2_SEL    = 16'h0840;
   localparam logic [15:0] OFF_IN3_SEL    = 16'h0850;
   localparam logic [15:0] OFF_IN4_SEL    = 16'h0860;
   localparam logic [15:0] OFF_IN_LEVELS  = 16'h08A0;
   localparam logic [15:0] OFF_OUT_POL    = 16'h08D0;
   localparam logic [15:0] OFF_OUT_SIM    = 16'h08E0;
   localparam logic [15:0] OFF_OUT1_SEL   = 16'h08F0;
   localparam logic [15:0] OFF_OUT2_SEL   = 16'h0900;
   localparam logic [15:0] OFF_OUT_LEVELS = 16'h0940;

   // ----------------------------------------------------------------
   // reset values and field widths
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_IN_POL  = 16'h00FF;
   localparam logic [15:0] RST_ZERO    = 16'h0000;
   localparam int          IN_SIM_BITS  = 8;
   localparam int          OUT_SIM_BITS = 5;
   localparam logic [15:0] CODE_PRE_ENABLE = 16'h8200;

   // ----------------------------------------------------------------
   // input function codes, same order as in_func_t (first = msb)
   // ----------------------------------------------------------------
   localparam int IN_FUNCS = 34;
   localparam logic [15:0] IN_CODES [IN_FUNCS] = '{
      16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
      16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800,
      16'h1000, 16'h2000, 16'h4000, 16'h8001, 16'h8002, 16'h8004,
      16'h8008, 16'h8010, 16'h8020, 16'h8040, 16'h8080, 16'h8100,
      16'h8200, 16'h8400, 16'h8800, 16'h9001, 16'h9002, 16'h9004,
      16'h9008, 16'h9010, 16'h9020, 16'h9040};

   typedef struct packed {
      logic drive_enable;
      logic error_reset;
      logic mode_control;
      logic vel_gain_control;
      logic pos_limit;
      logic neg_limit;
      logic home_signal;
      logic speed_reverse;
      logic speed_index0;
      logic speed_index1;
      logic pos_index0;
      logic pos_index1;
      logic emergency_stop;
      logic home_start;
      logic command_activate;
      logic speed_index2;
      logic pos_index2;
      logic multi_in0;
      logic multi_in1;
      logic multi_in2;
      logic gain_switch0;
      logic gain_switch1;
      logic max_current_toggle;
      logic motor_failure;
      logic pre_enable;
      logic capture1;
      logic capture2;
      logic table_cond0;
      logic table_cond1;
      logic table_activate;
      logic table_index0;
      logic table_index1;
      logic table_index2;
      logic table_terminate;
   } in_func_t;

   // ----------------------------------------------------------------
   // output function codes, same order as drive_state_t (first = msb)
   // ----------------------------------------------------------------
   localparam int OUT_FUNCS = 16;
   localparam logic [15:0] OUT_CODES [OUT_FUNCS] = '{
      16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
      16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800,
      16'h1000, 16'h2000, 16'h4000, 16'h9001};

   typedef struct packed {
      logic ready;
      logic error;
      logic pos_reached;
      logic zero_speed;
      logic brake;
      logic speed_reached;
      logic index_seen;
      logic torque_speed_limit;
      logic shaft_locked;
      logic in_limit;
      logic home_found;
      logic current_limit;
      logic multi_out0;
      logic multi_out1;
      logic multi_out2;
      logic table_running;
   } drive_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } par_req_t;

endpackage
`default_nettype wire

// ### core/out_chan.sv
// one physical output: function select, simulation and polarity
`default_nettype none
module out_chan (
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   input  wire logic [15:0]           code,
   input  wire io_map_pkg::drive_state_t state,
   input  wire logic                  sim,
   input  wire logic                  invert,
   output var  logic                  pin,
   output var  logic                  active
);
   logic [io_map_pkg::OUT_FUNCS-1:0] src_vec;
   logic                              sel;
   logic                              pin_reg;
   logic                              active_reg;

   assign src_vec = state;

   // picks the drive signal whose code is written (see R15) (see R16) (see R17)
   always_comb begin
      sel = 1'b0;
      for (int i = 0; i < io_map_pkg::OUT_FUNCS; i++) begin
         if (code == io_map_pkg::OUT_CODES[i]) sel = src_vec[io_map_pkg::OUT_FUNCS-1-i];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         active_reg <= 1'b0;
         pin_reg    <= 1'b0;
      end else begin
         active_reg <= sel | sim; // see R5
         pin_reg    <= (sel | sim) ^ invert;
      end
   end

   assign pin    = pin_reg;
   assign active = active_reg;
endmodule
`default_nettype wire

// ### core/servo_io_function_mapper.sv
// servo drive digital i/o port: parameter registers, input decode, output select
//
// Notes on behaviour
// R1: input status word bits 0-3 show inputs
// R2: output status word bits 0-1 show outputs
// R3: input polarity bits 0-7, default all set
// R4: input simulation word bits 0-7 writable
// R5: output simulation word bits 0-4 force outputs; the code forces outputs with bits 0-1 only
// R6: each input has 16-bit function select register
// R7: codes 0001-0008 enable, reset, mode, gain
// R8: codes 0010-0080 limits, home, speed reverse
// R9: speed and position index bit codes
// R10: codes 1000-4000 estop, homing, command activate
// R11: multi-function, gain switch, current toggle codes
// R12: motor failure, pre-enable, missing pre-enable alarms
// R13: codes 8400, 8800 fast capture channels
// R14: position table condition, activate, index, terminate
// R15: output codes 0001-0020 drive status signals
// R16: output codes 0040-0800 drive status signals
// R17: multi-function outputs and table running output
// R18: polarity bit inverts input before use
`default_nettype none
module servo_io_function_mapper #(
   parameter int N_IN  = 4,
   parameter int N_OUT = 2
) (
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic                 phys_input_one,
   input  wire logic                 phys_input_two,
   input  wire logic                 phys_input_three,
   input  wire logic                 phys_input_four,
   output var  logic                 phys_output_one,
   output var  logic                 phys_output_two,
   input  wire io_map_pkg::par_req_t par_req,
   output var  logic [15:0]          par_rdata,
   output var  logic                 par_ack,
   output var  logic                 par_err,
   input  wire io_map_pkg::drive_state_t drive_state,
   output var  io_map_pkg::in_func_t in_func,
   output var  logic                 pre_enable_alarm
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (N_IN != 4) begin : g_bad_in
      $error("servo_io_function_mapper: four physical inputs are wired");
   end
   if (N_OUT != 2) begin : g_bad_out
      $error("servo_io_function_mapper: two physical outputs are wired");
   end

   // ----------------------------------------------------------------
   // parameter registers
   // ----------------------------------------------------------------
   logic [15:0] in_pol_reg;
   logic [15:0] in_sim_reg;
   logic [15:0] in_sel_reg [N_IN];
   logic [15:0] out_pol_reg;
   logic [15:0] out_sim_reg;
   logic [15:0] out_sel_reg [N_OUT];

   logic        wr_hit;
   logic [N_IN-1:0]  in_sel_hit;
   logic [N_OUT-1:0] out_sel_hit;

   assign wr_hit = par_req.wr;

   always_comb begin
      for (int i = 0; i < N_IN; i++) in_sel_hit[i] = 1'b0;
      for (int i = 0; i < N_OUT; i++) out_sel_hit[i] = 1'b0;
      case (par_req.addr)
         io_map_pkg::OFF_IN1_SEL:  in_sel_hit[0] = 1'b1;
         io_map_pkg::OFF_IN2_SEL:  in_sel_hit[1] = 1'b1;
         io_map_pkg::OFF_IN3_SEL:  in_sel_hit[2] = 1'b1;
         io_map_pkg::OFF_IN4_SEL:  in_sel_hit[3] = 1'b1;
         io_map_pkg::OFF_OUT1_SEL: out_sel_hit[0] = 1'b1;
         io_map_pkg::OFF_OUT2_SEL: out_sel_hit[1] = 1'b1;
         default: ;
      endcase
   end

   // polarity word resets with all eight input bits set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         in_pol_reg <= io_map_pkg::RST_IN_POL; // see R3
      end else if (wr_hit && par_req.addr == io_map_pkg::OFF_IN_POL) begin
         in_pol_reg <= par_req.wdata; // see R3
      end
   end

   // simulation words keep all 16 bits; only bits 0-3 (input) and bits 0-1 (output) act
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         in_sim_reg  <= io_map_pkg::RST_ZERO;
         out_sim_reg <= io_map_pkg::RST_ZERO;
         out_pol_reg <= io_map_pkg::RST_ZERO;
      end else if (wr_hit) begin
         if (par_req.addr == io_map_pkg::OFF_IN_SIM)  in_sim_reg  <= par_req.wdata; // see R4
         if (par_req.addr == io_map_pkg::OFF_OUT_SIM) out_sim_reg <= par_req.wdata; // see R5
         if (par_req.addr == io_map_pkg::OFF_OUT_POL) out_pol_reg <= par_req.wdata;
      end
   end

   // function select registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < N_IN; i++) in_sel_reg[i] <= io_map_pkg::RST_ZERO;
         for (int i = 0; i < N_OUT; i++) out_sel_reg[i] <= io_map_pkg::RST_ZERO;
      end else if (wr_hit) begin
         for (int i = 0; i < N_IN; i++) begin
            if (in_sel_hit[i]) in_sel_reg[i] <= par_req.wdata; // see R6
         end
         for (int i = 0; i < N_OUT; i++) begin
            if (out_sel_hit[i]) out_sel_reg[i] <= par_req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // physical inputs
   // ----------------------------------------------------------------
   logic [N_IN-1:0] pin_in;
   logic [N_IN-1:0] in_level;

   assign pin_in = {phys_input_four, phys_input_three, phys_input_two, phys_input_one};

   for (genvar g = 0; g < N_IN; g++) begin : g_in
      in_chan u_in (
         .mclk   (mclk),
         .nrst   (nrst),
         .pin    (pin_in[g]),
         .invert (in_pol_reg[g]),
         .sim    (in_sim_reg[g]),
         .level  (in_level[g])
      );
   end

   // ----------------------------------------------------------------
   // input function decode
   // ----------------------------------------------------------------
   logic [io_map_pkg::IN_FUNCS-1:0] func_vec;
   logic [io_map_pkg::IN_FUNCS-1:0] func_reg;

   // each function is the or of all inputs carrying its code
   // (see R7) (see R8) (see R9) (see R10) (see R11) (see R13) (see R14)
   always_comb begin
      func_vec = '0;
      for (int f = 0; f < io_map_pkg::IN_FUNCS; f++) begin
         for (int i = 0; i < N_IN; i++) begin
            if (in_sel_reg[i] == io_map_pkg::IN_CODES[f] && in_level[i]) begin
               func_vec[io_map_pkg::IN_FUNCS-1-f] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) func_reg <= '0;
      else       func_reg <= func_vec;
   end

   assign in_func = func_reg;

   // ----------------------------------------------------------------
   // pre-enable supervision
   // ----------------------------------------------------------------
   logic pre_cfg;
   logic enable_d_reg;
   logic alarm_reg;
   logic alarm_set;
   io_map_pkg::in_func_t fn;

   assign fn = func_reg;

   always_comb begin
      pre_cfg = 1'b0;
      for (int i = 0; i < N_IN; i++) begin
         if (in_sel_reg[i] == io_map_pkg::CODE_PRE_ENABLE) pre_cfg = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) enable_d_reg <= 1'b0;
      else       enable_d_reg <= fn.drive_enable;
   end

   // enable arriving while a configured pre-enable is absent
   assign alarm_set = fn.drive_enable && !enable_d_reg && pre_cfg && !fn.pre_enable; // see R12

   // error reset clears the alarm, a new alarm wins over it
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)               alarm_reg <= 1'b0;
      else if (alarm_set)      alarm_reg <= 1'b1; // see R12
      else if (fn.error_reset) alarm_reg <= 1'b0;
   end

   assign pre_enable_alarm = alarm_reg;

   // ----------------------------------------------------------------
   // physical outputs
   // ----------------------------------------------------------------
   logic [N_OUT-1:0] pin_out;
   logic [N_OUT-1:0] out_active;

   for (genvar g = 0; g < N_OUT; g++) begin : g_out
      out_chan u_out (
         .mclk   (mclk),
         .nrst   (nrst),
         .code   (out_sel_reg[g]),
         .state  (drive_state),
         .sim    (out_sim_reg[g]),
         .invert (out_pol_reg[g]),
         .pin    (pin_out[g]),
         .active (out_active[g])
      );
   end

   assign phys_output_one = pin_out[0];
   assign phys_output_two = pin_out[1];

   // ----------------------------------------------------------------
   // parameter read port
   // ----------------------------------------------------------------
   logic [15:0] rdata_next;
   logic        known;
   logic        read_only;
   logic [15:0] rdata_reg;
   logic        ack_reg;
   logic        err_reg;

   always_comb begin
      rdata_next = '0;
      known      = 1'b1;
      read_only  = 1'b0;
      case (par_req.addr)
         io_map_pkg::OFF_IN_POL:   rdata_next = in_pol_reg;
         io_map_pkg::OFF_IN_SIM:   rdata_next = in_sim_reg;
         io_map_pkg::OFF_IN1_SEL:  rdata_next = in_sel_reg[0];
         io_map_pkg::OFF_IN2_SEL:  rdata_next = in_sel_reg[1];
         io_map_pkg::OFF_IN3_SEL:  rdata_next = in_sel_reg[2];
         io_map_pkg::OFF_IN4_SEL:  rdata_next = in_sel_reg[3];
         io_map_pkg::OFF_OUT_POL:  rdata_next = out_pol_reg;
         io_map_pkg::OFF_OUT_SIM:  rdata_next = out_sim_reg;
         io_map_pkg::OFF_OUT1_SEL: rdata_next = out_sel_reg[0];
         io_map_pkg::OFF_OUT2_SEL: rdata_next = out_sel_reg[1];
         io_map_pkg::OFF_IN_LEVELS: begin
            rdata_next[N_IN-1:0] = in_level; // see R1
            read_only            = 1'b1;
         end
         io_map_pkg::OFF_OUT_LEVELS: begin
            rdata_next[N_OUT-1:0] = out_active; // see R2
            read_only             = 1'b1;
         end
         default: known = 1'b0;
      endcase
   end

   // one-cycle answer to every access; unknown offset or write to status errs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= '0;
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
      end else begin
         ack_reg <= par_req.wr | par_req.rd;
         err_reg <= (par_req.wr | par_req.rd) & (!known | (par_req.wr & read_only));
         if (par_req.rd) rdata_reg <= rdata_next;
      end
   end

   assign par_rdata = rdata_reg;
   assign par_ack   = ack_reg;
   assign par_err   = err_reg;

endmodule
`default_nettype wire

// ### tb/io_field.sv
// switches and sensors wired to the drive's input pins
`default_nettype none
module io_field (
   input  wire logic       mclk,
   output var  logic [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pins = 4'h0;
   // pins change away from the sampling edge
   task automatic set_pins(input logic [3:0] v);
      @(negedge mclk);
      pins = v;
   endtask
endmodule
`default_nettype wire

// ### tb/io_map_props.sv
// assertion checker for the i/o function mapper ports
`default_nettype none
module io_map_props (
   input wire logic                     mclk,
   input wire logic                     nrst,
   input wire logic                     phys_output_one,
   input wire logic                     phys_output_two,
   input wire io_map_pkg::par_req_t     par_req,
   input wire logic [15:0]              par_rdata,
   input wire logic                     par_ack,
   input wire logic                     par_err,
   input wire io_map_pkg::drive_state_t drive_state,
   input wire io_map_pkg::in_func_t     in_func,
   input wire logic                     pre_enable_alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire logic acc = par_req.wr | par_req.rd;
   wire logic sim_wr = par_req.wr & !par_req.rd & (par_req.addr == io_map_pkg::OFF_IN_SIM);
   wire logic sim_rd = par_req.rd & !par_req.wr & (par_req.addr == io_map_pkg::OFF_IN_SIM);
   wire logic ro_wr = par_req.wr & (par_req.addr == io_map_pkg::OFF_IN_LEVELS |
                                    par_req.addr == io_map_pkg::OFF_OUT_LEVELS);

   // ----
   // parameter port
   // ----
   a_ack_follows_req: assert property (acc |=> par_ack)
      else $error("no ack after access");
   a_ack_needs_req: assert property (par_ack |-> $past(acc))
      else $error("ack without access");
   a_err_with_ack: assert property (par_err |-> par_ack)
      else $error("err without ack");
   a_status_ro_err: assert property (ro_wr |=> par_err)
      else $error("status word write accepted");
   a_sim_readback: assert property (sim_wr ##2 sim_rd |=> par_rdata == $past(par_req.wdata, 3))
      else $error("simulation word readback wrong");
   a_rdata_holds: assert property (!$past(par_req.rd) |-> $stable(par_rdata))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (par_req.rd && par_req.addr == 16'h0000 |=> par_err && par_rdata == 16'h0000)
      else $error("unmapped read not refused");

   // ----
   // pins and alarm
   // ----
   a_out_pins_hold: assert property ((!par_req.wr ##1 $stable(drive_state))
         |=> $stable(phys_output_one) && $stable(phys_output_two))
      else $error("output pin moved without cause");
   a_alarm_sticky: assert property (pre_enable_alarm && !in_func.error_reset |=> pre_enable_alarm)
      else $error("alarm dropped without reset");

   c_refused: cover property (par_err);
   c_alarm: cover property ($rose(pre_enable_alarm));
   c_out_rise: cover property ($rose(phys_output_one));
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the servo i/o function mapper
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     mclk;
   logic                     nrst;
   logic [3:0]               pins;
   logic                     out_one;
   logic                     out_two;
   io_map_pkg::par_req_t     par_req;
   logic [15:0]              par_rdata;
   logic                     par_ack;
   logic                     par_err;
   io_map_pkg::drive_state_t drive_state;
   io_map_pkg::in_func_t     in_func;
   logic                     alarm;
   int                       n_fail;
   int                       n_checks;
   logic [15:0]              rd_val;
   logic                     rd_err;
   logic [15:0]              pol;
   logic [15:0]              sim;
   logic [15:0]              a;
   logic [15:0]              ds;
   logic [1:0]               act;

   servo_io_function_mapper u_servo_io_function_mapper (
      .mclk(mclk), .nrst(nrst),
      .phys_input_one(pins[0]), .phys_input_two(pins[1]),
      .phys_input_three(pins[2]), .phys_input_four(pins[3]),
      .phys_output_one(out_one), .phys_output_two(out_two),
      .par_req(par_req), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
      .drive_state(drive_state), .in_func(in_func), .pre_enable_alarm(alarm));
   io_field u_io_field (.mclk(mclk), .pins(pins));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one access: request one cycle, answer sampled mid next cycle
   task automatic acc(input logic w, input logic [15:0] ad, input logic [15:0] d);
      @(negedge mclk);
      par_req = '{w, !w, ad, d};
      @(negedge mclk);
      par_req = '0;
      chk("ack", 34'(par_ack), 34'h1);
      rd_val = par_rdata;
      rd_err = par_err;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      test_done();
   end

   initial begin
      nrst = 1'b0;
      par_req = '0;
      drive_state = '0;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(10));
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      // ----
      // reset values and readback of all writable words
      // ----
      for (int i = 0; i < 10; i++) begin
         a = i < 6 ? 16'(io_map_pkg::OFF_IN_POL + 16'h10 * i) : 16'(io_map_pkg::OFF_OUT_POL + 16'h10 * (i - 6));
         acc(1'b0, a, 16'h0000);
         chk("reset", 34'(rd_val), i == 0 ? 34'h00FF : 34'h0);
         ds = 16'($urandom);
         acc(1'b1, a, ds);
         acc(1'b0, a, 16'h0000);
         chk("readback", 34'({rd_err, rd_val}), 34'({1'b0, ds}));
      end
      acc(1'b1, io_map_pkg::OFF_IN_LEVELS, 16'hFFFF);
      chk("ro err", 34'(rd_err), 34'h1);
      acc(1'b1, io_map_pkg::OFF_OUT_LEVELS, 16'hFFFF);
      chk("ro err", 34'(rd_err), 34'h1);
      acc(1'b0, 16'h0000, 16'h0000);
      chk("unmapped", 34'({rd_err, rd_val}), 34'h10000);
      $display("test registers done");
      // ----
      // input levels with polarity and simulation
      // ----
      for (int k = 0; k < 20; k++) begin
         pol = k == 0 ? 16'h0000 : k == 1 ? 16'h00FF : 16'($urandom);
         sim = k < 4 ? 16'h0000 : 16'($urandom);
         acc(1'b1, io_map_pkg::OFF_IN_POL, pol);
         acc(1'b1, io_map_pkg::OFF_IN_SIM, sim);
         u_io_field.set_pins(4'($urandom));
         repeat (4) @(negedge mclk);
         acc(1'b0, io_map_pkg::OFF_IN_LEVELS, 16'h0000);
         chk("in level", 34'(rd_val[3:0]), 34'((pins ^ pol[3:0]) | sim[3:0]));
      end
      $display("test input levels done");
      // ----
      // every input code on a rotating input, plus one unknown code
      // ----
      acc(1'b1, io_map_pkg::OFF_IN_POL, 16'h0000);
      acc(1'b1, io_map_pkg::OFF_IN_SIM, 16'h0000);
      for (int i = 0; i <= io_map_pkg::IN_FUNCS; i++) begin
         a = 16'(io_map_pkg::OFF_IN1_SEL + 16'h10 * (i % 4));
         acc(1'b1, a, i < io_map_pkg::IN_FUNCS ? io_map_pkg::IN_CODES[i] : 16'h0003);
         u_io_field.set_pins(4'(1 << (i % 4)));
         repeat (5) @(negedge mclk);
         chk("in func", in_func, i < io_map_pkg::IN_FUNCS ? 34'(1) << (33 - i) : 34'h0);
         u_io_field.set_pins(4'h0);
         repeat (5) @(negedge mclk);
         chk("in func idle", in_func, 34'h0);
         acc(1'b1, a, 16'h0000);
      end
      $display("test input functions done");
      // ----
      // every output code with random state, polarity and simulation
      // ----
      for (int i = 0; i < io_map_pkg::OUT_FUNCS; i++) begin
         pol = 16'($urandom);
         sim = i < 8 ? 16'h0000 : 16'($urandom);
         acc(1'b1, io_map_pkg::OFF_OUT_POL, pol);
         acc(1'b1, io_map_pkg::OFF_OUT_SIM, sim);
         acc(1'b1, io_map_pkg::OFF_OUT1_SEL, io_map_pkg::OUT_CODES[i]);
         acc(1'b1, io_map_pkg::OFF_OUT2_SEL, io_map_pkg::OUT_CODES[15 - i]);
         ds = 16'($urandom);
         drive_state = ds;
         repeat (2) @(negedge mclk);
         act = {ds[i] | sim[1], ds[15 - i] | sim[0]};
         chk("out pins", 34'({out_two, out_one}), 34'(act ^ pol[1:0]));
         acc(1'b0, io_map_pkg::OFF_OUT_LEVELS, 16'h0000);
         chk("out level", 34'(rd_val[1:0]), 34'(act));
      end
      $display("test outputs done");
      // ----
      // enable with and without the pre-enable input
      // ----
      acc(1'b1, io_map_pkg::OFF_IN1_SEL, io_map_pkg::CODE_PRE_ENABLE);
      acc(1'b1, io_map_pkg::OFF_IN2_SEL, 16'h0001);
      acc(1'b1, io_map_pkg::OFF_IN3_SEL, 16'h0002);
      u_io_field.set_pins(4'h2);
      repeat (6) @(negedge mclk);
      chk("alarm set", 34'(alarm), 34'h1);
      u_io_field.set_pins(4'h4);
      repeat (6) @(negedge mclk);
      chk("alarm clear", 34'(alarm), 34'h0);
      u_io_field.set_pins(4'h1);
      repeat (6) @(negedge mclk);
      u_io_field.set_pins(4'h3);
      repeat (6) @(negedge mclk);
      chk("alarm quiet", 34'(alarm), 34'h0);
      $display("test pre-enable done");
      test_done();
   end
endmodule

bind servo_io_function_mapper io_map_props u_io_map_props (
   .mclk(mclk), .nrst(nrst), .phys_output_one(phys_output_one), .phys_output_two(phys_output_two),
   .par_req(par_req), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
   .drive_state(drive_state), .in_func(in_func), .pre_enable_alarm(pre_enable_alarm));
`default_nettype wire
